// file: csenc_params.svh
// Purpose: Constants for the channel-status switch encoder
// Assumes: Included by bare name
// Notes:   Offsets are byte addresses on the register bus
`ifndef CSENC_PARAMS_SVH
`define CSENC_PARAMS_SVH

// ----------------------------------------------------------
// Block geometry
// ----------------------------------------------------------
`define CSENC_CS_BITS      192
`define CSENC_BLK_FRAMES   192
`define CSENC_ADDR_W       8

// ----------------------------------------------------------
// Register offsets and reset values
// ----------------------------------------------------------
`define CSENC_OFF_CTRL     8'h00
`define CSENC_OFF_SW_LIVE  8'h04
`define CSENC_OFF_SW_ACT   8'h08
`define CSENC_OFF_STATUS   8'h0c
`define CSENC_OFF_TBL_LO   8'h40
`define CSENC_OFF_TBL_HI   8'h9c
`define CSENC_CTRL_RST     2'h0
`define CSENC_SW_RST       8'hff
`define CSENC_CTRL_EXT     0
`define CSENC_CTRL_TBL     1
`define CSENC_ST_PRO       8
`define CSENC_ST_LARE      9
`define CSENC_ST_LOCK      10
`define CSENC_ST_BLKCNT    16
`define CSENC_RESP_OKAY    2'h0
`define CSENC_RESP_SLVERR  2'h2

// ----------------------------------------------------------
// Switch positions (switch n sits at bit n-1)
// ----------------------------------------------------------
`define CSENC_SW1          0
`define CSENC_SW2          1
`define CSENC_SW3          2
`define CSENC_SW4          3
`define CSENC_SW5          4
`define CSENC_SW6          5
`define CSENC_SW7          6
`define CSENC_SW8          7

// ----------------------------------------------------------
// Channel-status bit positions
// ----------------------------------------------------------
`define CSENC_CB_PRO       0
`define CSENC_CB_AUDIO     1
`define CSENC_CB_EMPH      2
`define CSENC_CB_RATE      6
`define CSENC_CB_CAT       8
`define CSENC_CB_MODE      9
`define CSENC_CB_GEN       15
`define CSENC_CB_FREQ      24
`define CSENC_CB_COPY      2
`define CSENC_CB_CEMPH     3

`endif

// file: csenc_pkg.sv
// Purpose: Types for the channel-status switch encoder
// Assumes: csenc_params.svh on the include path
// Notes:   Constants live in the header
`default_nettype none
`include "csenc_params.svh"
package csenc_pkg;
  typedef logic [7:0]                  csenc_sw_t;
  typedef logic [`CSENC_CS_BITS-1:0]   csenc_word_t;
  typedef enum logic {WR_COLLECT, WR_RESP} csenc_wr_state_t;
endpackage
`default_nettype wire

// file: csenc_mem.sv
// Purpose: Byte table of extra channel-status bits
// Assumes: One write and one read port, same clock
// Notes:   Read data come out of a register
`default_nettype none
`timescale 1ns/100ps
module csenc_mem #(
  parameter int DEPTH = 24,
  parameter int AW    = 5
) (
  // Clock and reset
  input  wire logic          aclk,
  input  wire logic          aresetn,
  // Write port
  input  wire logic          we,
  input  wire logic [AW-1:0] waddr,
  input  wire logic [7:0]    wdata,
  // Read port
  input  wire logic [AW-1:0] raddr,
  output var  logic [7:0]    rdata_q
);
  logic [7:0] mem_q [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("csenc_mem: DEPTH does not fit AW");
  end

  // Table storage, cleared by reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < DEPTH; i++) begin
        mem_q[i] <= 8'h00;
      end
    end else if (we && (int'(waddr) < DEPTH)) begin
      mem_q[waddr] <= wdata;
    end
  end

  // Registered read
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 8'h00;
    end else if (int'(raddr) < DEPTH) begin
      rdata_q <= mem_q[raddr];
    end else begin
      rdata_q <= 8'h00;
    end
  end
endmodule // csenc_mem
`default_nettype wire

// file: csenc_top.sv
// Purpose: Switch bank to channel-status bit stream encoder
// Assumes: Inputs synchronous to aclk; strobes >= 2 cycles apart
// Notes:   Switch closed reads 0, open reads 1
`default_nettype none
`timescale 1ns/100ps
`include "csenc_params.svh"

module csenc_top #(
  parameter int FRAMES = `CSENC_BLK_FRAMES,
  parameter int TBL_D  = `CSENC_BLK_FRAMES / 8
) (
  // Clock and reset
  input  wire logic                     aclk,
  input  wire logic                     aresetn,
  // Switch bank and serial input
  input  wire logic [7:0]               switch_in,
  input  wire logic                     ext_cs_in,
  // Transmitter side
  input  wire logic                     frame_strobe,
  input  wire logic                     block_boundary_out,
  output var  logic                     cs_bit_q,
  output var  logic                     pro_consumer_select,
  output var  logic                     local_addr_reliability_enable,
  // AXI4-Lite write address and data
  input  wire logic [`CSENC_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                     s_axi_awvalid,
  output var  logic                     s_axi_awready,
  input  wire logic [31:0]              s_axi_wdata,
  input  wire logic [3:0]               s_axi_wstrb,
  input  wire logic                     s_axi_wvalid,
  output var  logic                     s_axi_wready,
  // AXI4-Lite write response
  output var  logic [1:0]               s_axi_bresp,
  output var  logic                     s_axi_bvalid,
  input  wire logic                     s_axi_bready,
  // AXI4-Lite read
  input  wire logic [`CSENC_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                     s_axi_arvalid,
  output var  logic                     s_axi_arready,
  output var  logic [31:0]              s_axi_rdata,
  output var  logic [1:0]               s_axi_rresp,
  output var  logic                     s_axi_rvalid,
  input  wire logic                     s_axi_rready
);
  // ----------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------
  localparam int TAW = 5;

  csenc_pkg::csenc_sw_t            sw_q;
  csenc_pkg::csenc_sw_t            act_sw_q;
  csenc_pkg::csenc_word_t          act_word;
  csenc_pkg::csenc_word_t          word_now;
  csenc_pkg::csenc_wr_state_t      wst_q;
  logic [1:0]                      ctrl_q;
  logic                            cbl_prev_q;
  logic                            locked_q;
  logic [7:0]                      fc_q;
  logic [7:0]                      idx;
  logic [7:0]                      fc_d;
  logic [15:0]                     blkcnt_q;
  logic                            blk_start;
  logic                            mem_bit;
  logic                            ext_bit;
  logic                            cs_bit_d;
  logic [7:0]                      tbl_rdata;
  logic [1:0]                      pro_rate_bits;
  logic                            channel_mode_bit_inv;
  logic                            aw_held_q;
  logic                            w_held_q;
  logic [`CSENC_ADDR_W-1:0]        awaddr_q;
  logic [31:0]                     wdata_q;
  logic [3:0]                      wstrb_q;
  logic                            wr_fire;
  logic                            tbl_we;
  logic [31:0]                     rd_word;
  logic                            rd_hit;
  logic                            wr_hit;

  // Elaboration-time range check
  if (FRAMES < 32 || FRAMES > `CSENC_CS_BITS || (FRAMES % 8) != 0 ||
      TBL_D != FRAMES / 8) begin : g_bad_frames
    $error("csenc_top: FRAMES must be 32..192, a multiple of 8");
  end

  // ----------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------
  // Channel-status word from a switch set
  function automatic csenc_pkg::csenc_word_t cs_word(
      input csenc_pkg::csenc_sw_t s);
    csenc_pkg::csenc_word_t w;
    w = '0;
    if (!s[`CSENC_SW3]) begin
      w[`CSENC_CB_PRO]    = 1'b1;
      w[`CSENC_CB_AUDIO]  = ~s[`CSENC_SW4];
      w[`CSENC_CB_RATE]   = ~s[`CSENC_SW5];
      w[`CSENC_CB_RATE+1] = ~s[`CSENC_SW2];
      w[`CSENC_CB_MODE]   = ~s[`CSENC_SW6];
      w[`CSENC_CB_EMPH]   = ~(s[`CSENC_SW8] & s[`CSENC_SW7]);
      w[`CSENC_CB_EMPH+1] = ~s[`CSENC_SW8];
      w[`CSENC_CB_EMPH+2] = ~s[`CSENC_SW8] & ~s[`CSENC_SW7];
      // Bytes 14-17 and 22 stay zero; transmitter fills them
    end else begin
      w[`CSENC_CB_PRO]    = 1'b0;
      w[`CSENC_CB_FREQ]   = s[`CSENC_SW1] & ~s[`CSENC_SW4];
      w[`CSENC_CB_FREQ+1] = s[`CSENC_SW1] ^ s[`CSENC_SW4];
      w[`CSENC_CB_CEMPH]  = ~s[`CSENC_SW2];
      w[`CSENC_CB_COPY]   = ~s[`CSENC_SW5];
      w[`CSENC_CB_GEN]    = ~s[`CSENC_SW6];
      w[`CSENC_CB_CAT]    = ~s[`CSENC_SW8];
      w[`CSENC_CB_CAT+1]  = ~s[`CSENC_SW7];
    end
    return w;
  endfunction

  // Register-map hit test
  function automatic logic map_hit(input logic [`CSENC_ADDR_W-1:0] a);
    return (a == `CSENC_OFF_CTRL)    || (a == `CSENC_OFF_SW_LIVE) ||
           (a == `CSENC_OFF_SW_ACT)  || (a == `CSENC_OFF_STATUS)  ||
           ((a >= `CSENC_OFF_TBL_LO) && (a <= `CSENC_OFF_TBL_HI) &&
            (a[1:0] == 2'b00));
  endfunction

  // ----------------------------------------------------------
  // Switch capture and block alignment
  // ----------------------------------------------------------
  // Live switch sample
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sw_q <= `CSENC_SW_RST;
    end else begin
      sw_q <= switch_in;
    end
  end

  // Block start on rising boundary output at a frame strobe
  assign blk_start = frame_strobe && block_boundary_out &&
                     !cbl_prev_q;

  // Boundary history, taken once per frame
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cbl_prev_q <= 1'b0;
    end else if (frame_strobe) begin
      cbl_prev_q <= block_boundary_out;
    end
  end

  // Active switch set, updated only at a block start
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      act_sw_q <= `CSENC_SW_RST;
    end else if (blk_start) begin
      act_sw_q <= sw_q;
    end
  end

  // Lock flag and block counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      locked_q <= 1'b0;
      blkcnt_q <= 16'h0000;
    end else if (blk_start) begin
      locked_q <= 1'b1;
      blkcnt_q <= blkcnt_q + 16'h0001;
    end
  end

  // Mode pins follow the active set
  assign act_word                      = cs_word(act_sw_q);
  assign pro_consumer_select           = act_sw_q[`CSENC_SW3];
  assign local_addr_reliability_enable = !act_sw_q[`CSENC_SW3] &&
                                         act_sw_q[`CSENC_SW1];
  assign pro_rate_bits        = act_word[`CSENC_CB_RATE+1:`CSENC_CB_RATE];
  assign channel_mode_bit_inv = act_word[`CSENC_CB_MODE];

  // ----------------------------------------------------------
  // Bit serializer
  // ----------------------------------------------------------
  // Frame index and next bit
  always_comb begin
    idx      = blk_start ? 8'h00 : fc_q;
    word_now = blk_start ? cs_word(sw_q) : act_word;
    fc_d     = (int'(idx) == FRAMES - 1) ? 8'h00 : idx + 8'h01;
    ext_bit  = ctrl_q[`CSENC_CTRL_EXT] && ext_cs_in;
    mem_bit  = ctrl_q[`CSENC_CTRL_TBL] && tbl_rdata[idx[2:0]] &&
               (!blk_start || fc_q[7:3] == 5'h00);
    cs_bit_d = word_now[idx] | ext_bit | mem_bit;
  end

  // Output bit and frame counter, advanced per frame strobe
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cs_bit_q <= 1'b0;
      fc_q     <= 8'h00;
    end else if (frame_strobe) begin
      cs_bit_q <= cs_bit_d;
      fc_q     <= fc_d;
    end
  end

  // Extra-bit table, read one cycle ahead of the strobe
  csenc_mem #(
    .DEPTH (TBL_D),
    .AW    (TAW)
  ) u_tbl (
    .aclk    (aclk),
    .aresetn (aresetn),
    .we      (tbl_we),
    .waddr   (TAW'((awaddr_q - `CSENC_OFF_TBL_LO) >> 2)),
    .wdata   (wdata_q[7:0]),
    .raddr   (fc_q[7:3]),
    .rdata_q (tbl_rdata)
  );

  // ----------------------------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------------------------
  assign s_axi_awready = !aw_held_q && (wst_q == csenc_pkg::WR_COLLECT);
  assign s_axi_wready  = !w_held_q && (wst_q == csenc_pkg::WR_COLLECT);
  assign wr_fire = aw_held_q && w_held_q &&
                   (wst_q == csenc_pkg::WR_COLLECT);
  assign wr_hit  = map_hit(awaddr_q);
  assign tbl_we  = wr_fire && wr_hit && s_axi_wstrb_ok();

  // Table writes need byte lane 0 and a table address
  function automatic logic s_axi_wstrb_ok();
    return wstrb_q[0] && (awaddr_q >= `CSENC_OFF_TBL_LO);
  endfunction

  // Address and data holding, taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      awaddr_q  <= '0;
      wdata_q   <= 32'h0000_0000;
      wstrb_q   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_q <= 1'b0;
      end
    end
  end

  // Write response state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wst_q        <= csenc_pkg::WR_COLLECT;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CSENC_RESP_OKAY;
    end else begin
      unique case (wst_q)
        csenc_pkg::WR_COLLECT: begin
          if (wr_fire) begin
            wst_q        <= csenc_pkg::WR_RESP;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? `CSENC_RESP_OKAY
                                   : `CSENC_RESP_SLVERR;
          end
        end
        csenc_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wst_q        <= csenc_pkg::WR_COLLECT;
            s_axi_bvalid <= 1'b0;
          end
        end
      endcase
    end
  end

  // Control register, byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `CSENC_CTRL_RST;
    end else if (wr_fire && awaddr_q == `CSENC_OFF_CTRL &&
                 wstrb_q[0]) begin
      ctrl_q <= wdata_q[1:0];
    end
  end

  // ----------------------------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit        = map_hit(s_axi_araddr);

  // Read mux; table window is write-only and reads zero
  always_comb begin
    rd_word = 32'h0000_0000;
    unique case (s_axi_araddr)
      `CSENC_OFF_CTRL:    rd_word[1:0] = ctrl_q;
      `CSENC_OFF_SW_LIVE: rd_word[7:0] = sw_q;
      `CSENC_OFF_SW_ACT:  rd_word[7:0] = act_sw_q;
      `CSENC_OFF_STATUS: begin
        rd_word[7:0]              = fc_q;
        rd_word[`CSENC_ST_PRO]    = pro_consumer_select;
        rd_word[`CSENC_ST_LARE]   = local_addr_reliability_enable;
        rd_word[`CSENC_ST_LOCK]   = locked_q;
        rd_word[31:`CSENC_ST_BLKCNT] = blkcnt_q;
      end
      default:            rd_word = 32'h0000_0000;
    endcase
  end

  // Read data register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `CSENC_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_hit ? `CSENC_RESP_OKAY : `CSENC_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_pro_frame_zero: assert property (
    blk_start && !sw_q[`CSENC_SW3] |=> cs_bit_q && !pro_consumer_select)
    else $error("Professional block did not send bit 0 high");

  chk_consumer_mode: assert property (
    blk_start && sw_q[`CSENC_SW3] && !ext_bit && !mem_bit
    |=> !cs_bit_q && pro_consumer_select)
    else $error("Consumer block did not send bit 0 low");

  chk_lare_enable: assert property (
    blk_start && !sw_q[`CSENC_SW3] && sw_q[`CSENC_SW1]
    |=> local_addr_reliability_enable [*2])
    else $error("Address and reliability enable not raised");

  chk_rate_bits: assert property (
    !pro_consumer_select |-> pro_rate_bits ==
      ~{act_sw_q[`CSENC_SW2], act_sw_q[`CSENC_SW5]})
    else $error("Professional rate bits wrong");

  chk_audio_mode_bits: assert property (
    !pro_consumer_select |-> act_word[1] != act_sw_q[`CSENC_SW4] &&
      act_word[11:8] == {2'b00, ~act_sw_q[`CSENC_SW6], 1'b0} &&
      channel_mode_bit_inv == act_word[9])
    else $error("Audio or channel-mode bits wrong");

  chk_pro_emphasis: assert property (
    !pro_consumer_select && act_sw_q[`CSENC_SW8] &&
    !act_sw_q[`CSENC_SW7] |-> act_word[4:2] == 3'b001)
    else $error("Professional no-emphasis code wrong");

  chk_serial_or: assert property (
    frame_strobe && ctrl_q[`CSENC_CTRL_EXT] && ext_cs_in |=> cs_bit_q)
    else $error("Serial channel-status bit lost");

  chk_cons_freq: assert property (
    pro_consumer_select && act_sw_q[`CSENC_SW1] && !act_sw_q[`CSENC_SW4]
    |-> act_word[27:24] == 4'b0011)
    else $error("Consumer 32 kHz code wrong");

  chk_cons_fields: assert property (
    pro_consumer_select |-> act_word[3] == ~act_sw_q[`CSENC_SW2] &&
      act_word[2] == ~act_sw_q[`CSENC_SW5] &&
      act_word[15] == ~act_sw_q[`CSENC_SW6] &&
      act_word[9:8] == ~{act_sw_q[`CSENC_SW7], act_sw_q[`CSENC_SW8]})
    else $error("Consumer field bits wrong");

  chk_word_hold: assert property (
    !blk_start |=> $stable(act_sw_q))
    else $error("Switch set changed inside a block");

  chk_bit_hold: assert property (
    !frame_strobe |=> $stable(cs_bit_q) && $stable(fc_q))
    else $error("Output bit moved without a frame strobe");
endmodule // csenc_top
`default_nettype wire

// file: csenc_tx_model.sv
// Purpose: Transmitter model making frame strobes and collecting cs bits
// Assumes: One strobe every four aclk cycles, block sync high frames 0-95
// Notes:   ext_cs_in shows the inverse of its bit between strobes
`default_nettype none
`timescale 1ns/100ps
module csenc_tx_model (
  // Clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // Encoder side
  input  wire logic                   cs_bit_q,
  output var  logic                   frame_strobe,
  output var  logic                   block_boundary_out,
  output var  logic                   ext_cs_in,
  // Bench side
  input  wire csenc_pkg::csenc_word_t ext_word,
  output var  csenc_pkg::csenc_word_t rx_word,
  output var  logic                   blk_done
);
  // ------------------------------------------------------------
  // Frame timing
  // ------------------------------------------------------------
  logic [1:0] cnt_q;
  logic [7:0] idx_q;
  // Strobe, block sync and serial bits aligned to the frame index
  always_comb begin
    frame_strobe       = aresetn && (cnt_q == 2'h0);
    block_boundary_out = (idx_q < 8'h60);
    ext_cs_in          = frame_strobe ? ext_word[idx_q] : ~ext_word[idx_q];
  end
  // Collect each bit one cycle after its strobe, flag the block end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q    <= 2'h0;
      idx_q    <= 8'h00;
      blk_done <= 1'b0;
    end else begin
      cnt_q    <= cnt_q + 2'h1;
      blk_done <= 1'b0;
      if (cnt_q == 2'h1) begin
        rx_word[idx_q] <= cs_bit_q;
        idx_q          <= (idx_q == 8'hbf) ? 8'h00 : idx_q + 8'h01;
        blk_done       <= (idx_q == 8'hbf);
      end
    end
  end
endmodule // csenc_tx_model
`default_nettype wire

// file: tb_channel_status_switch_encoder.sv
// Purpose: Self-checking bench for the channel-status switch encoder
// Assumes: Transmitter model on the link side, AXI4-Lite master tasks
// Notes:   Switch sets change mid-block and must wait for the next block
`default_nettype none
`timescale 1ns/100ps
`include "csenc_params.svh"
module tb_channel_status_switch_encoder;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic        aclk = 1'b0, aresetn = 1'b0, ext_cs_in, frame_strobe;
  logic        block_boundary_out, cs_bit_q, pro_sel, lare, blk_done;
  logic        awvalid = 1'b0, awready, wvalid = 1'b0, wready, bvalid;
  logic        arvalid = 1'b0, arready, rvalid, rready = 1'b0, bready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00, seed = 8'h60;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  csenc_pkg::csenc_sw_t   switch_in = 8'hff, exp_sw = 8'hff, nxt;
  csenc_pkg::csenc_word_t ext_word = '0, tbl = '0, rx_word, tmp;
  csenc_pkg::csenc_sw_t   corner [9] = '{8'hff, 8'h00, 8'hfb, 8'h04,
                                         8'h58, 8'ha1, 8'h45, 8'hca, 8'h8c};
  int          err_count = 0, samples_checked = 0, cyc = 0;
  // Clock at 100 MHz
  initial forever #5 aclk = ~aclk;
  csenc_top i_dut (.aclk(aclk), .aresetn(aresetn), .switch_in(switch_in),
    .ext_cs_in(ext_cs_in), .frame_strobe(frame_strobe),
    .block_boundary_out(block_boundary_out), .cs_bit_q(cs_bit_q),
    .pro_consumer_select(pro_sel), .local_addr_reliability_enable(lare),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  csenc_tx_model i_tx (.aclk(aclk), .aresetn(aresetn), .cs_bit_q(cs_bit_q),
    .frame_strobe(frame_strobe), .block_boundary_out(block_boundary_out),
    .ext_cs_in(ext_cs_in), .ext_word(ext_word), .rx_word(rx_word),
    .blk_done(blk_done));
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  // Expected channel-status word for a switch set and OR sources
  function automatic csenc_pkg::csenc_word_t exp_word(
      input csenc_pkg::csenc_sw_t s, input logic [1:0] c,
      input csenc_pkg::csenc_word_t e, input csenc_pkg::csenc_word_t t);
    csenc_pkg::csenc_word_t w;
    w = '0;
    if (!s[2]) begin
      w[0] = 1'b1;
      w[1] = ~s[3];
      w[2] = ~(s[7] & s[6]);
      w[3] = ~s[7];
      w[4] = ~s[7] & ~s[6];
      w[6] = ~s[4];
      w[7] = ~s[1];
      w[9] = ~s[5];
    end else begin
      w[24] = s[0] & ~s[3];
      w[25] = s[0] ^ s[3];
      w[3] = ~s[1];
      w[2] = ~s[4];
      w[15] = ~s[5];
      w[8] = ~s[7];
      w[9] = ~s[6];
    end
    return w | (c[0] ? e : '0) | (c[1] ? t : '0);
  endfunction
  task automatic check(input csenc_pkg::csenc_word_t seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  // AXI4-Lite write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
    @(posedge aclk);
  endtask
  // AXI4-Lite read
  task automatic axi_rd(input logic [7:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
    rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic wait_done();
    do @(posedge aclk); while (blk_done !== 1'b1);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // Hang guard
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 40000) begin
      err_count++;
      complete_run();
    end
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (11) @(posedge aclk);
    check(192'(pro_sel), 192'(1'b1));
    check(192'(lare), 192'(1'b0));
    @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    axi_rd(`CSENC_OFF_CTRL);
    check(192'(rd), 192'(32'h0));
    for (int i = 0; i < 12; i++) begin
      wait_done();
      check(rx_word, exp_word(exp_sw, 2'h0, ext_word, tbl));
      exp_sw = switch_in;
      repeat (300) @(posedge aclk);
      check(192'(pro_sel), 192'(exp_sw[2]));
      check(192'(lare), 192'(~exp_sw[2] & exp_sw[0]));
      axi_rd(`CSENC_OFF_SW_ACT);
      check(192'(rd), 192'({24'h0, exp_sw}));
      seed = lfsr(seed);
      nxt = (i < 8) ? corner[i+1] : seed;
      switch_in <= nxt;
    end
    $display("test switch blocks done");
    axi_wr(`CSENC_OFF_CTRL, 32'h3);
    for (int j = 0; j < 24; j++) begin
      seed = lfsr(seed);
      tbl[8*j+:8] = seed;
      tmp[8*j+:8] = lfsr(seed) ^ 8'h5a;
      axi_wr(8'h40 + 8'(4*j), {24'h0, seed});
    end
    ext_word <= tmp;
    wait_done();
    wait_done();
    check(rx_word, exp_word(switch_in, 2'h3, ext_word, tbl));
    $display("test serial and table OR done");
    axi_rd(`CSENC_OFF_CTRL);
    check(192'(rd), 192'(32'h3));
    axi_rd(`CSENC_OFF_SW_LIVE);
    check(192'(rd), 192'({24'h0, switch_in}));
    axi_rd(`CSENC_OFF_STATUS);
    check(192'(rd[10:8]), 192'({1'b1, ~switch_in[2] & switch_in[0],
                               switch_in[2]}));
    axi_rd(8'h20);
    check(192'({resp, rd}), 192'({`CSENC_RESP_SLVERR, 32'h0}));
    axi_wr(8'h30, 32'h3);
    check(192'(resp), 192'(`CSENC_RESP_SLVERR));
    axi_rd(`CSENC_OFF_TBL_LO);
    check(192'({resp, rd}), 192'({`CSENC_RESP_OKAY, 32'h0}));
    $display("test register map done");
    complete_run();
  end
endmodule // tb_channel_status_switch_encoder
`default_nettype wire
